/* bench/clkreg_bank_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module clkreg_bank_monitor (
  input wire logic mclk, reset, reg_wr, reg_rd, reg_hit, hd_xpt_run,
  input wire logic hd1001_xpt_run, hd_loop_halve, hd_loop_run,
  input wire logic hd1001_loop_halve, hd1001_loop_run, audio_loop_run,
  input wire logic audio_ref_freq_select, audio_ref_source_select,
  input wire logic [3:0] hd_loop_pump_current, hd1001_loop_pump_current,
  input wire logic [3:0] audio_loop_pow2_divider, audio_loop_pump_current,
  input wire clkreg_pkg::clkreg_byte_t reg_addr, reg_wdata, reg_rdata,
  input wire clkreg_pkg::clkreg_byte_t hd_loop_osc_range,
  input wire clkreg_pkg::clkreg_byte_t hd1001_loop_osc_range);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_wr(a); reg_wr && reg_addr == a; endsequence
  property p_hd; s_wr(8'h2e) |=> hd_loop_halve == $past(reg_wdata[4])
    && hd_loop_run == (hd_xpt_run && !$past(reg_wdata[3])); endproperty
  a_hd: assert property (p_hd) else $error("hd main");
  property p_hd3; s_wr(8'h31) |=> hd1001_loop_halve == $past(reg_wdata[4])
    && hd1001_loop_run == (hd1001_xpt_run && !$past(reg_wdata[3]));
  endproperty
  a_hd3: assert property (p_hd3) else $error("hd1001 main");
  property p_aud; s_wr(8'h34) |=> audio_loop_pow2_divider == $past(
    reg_wdata[7:4]) && audio_loop_run == !$past(reg_wdata[3]); endproperty
  a_aud: assert property (p_aud) else $error("audio main");
  property p_sel; s_wr(8'h34) |=> {audio_ref_freq_select,
    audio_ref_source_select} == $past(reg_wdata[1:0]); endproperty
  a_sel: assert property (p_sel) else $error("audio select");
  property p_pump; s_wr(8'h35) |=>
    audio_loop_pump_current == $past(reg_wdata[3:0]); endproperty
  a_pump: assert property (p_pump) else $error("pump");
  property p_osc; s_wr(8'h33) |=>
    hd1001_loop_osc_range == $past(reg_wdata); endproperty
  a_osc: assert property (p_osc) else $error("osc range");
  property p_rsv; reg_rd && reg_addr inside {8'h2f, 8'h32, 8'h35} |=>
    reg_rdata[7:4] == 4'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits");
  property p_unm; reg_rd && !reg_hit |=> reg_rdata == 8'h00; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_hold; !reg_wr |=> $stable(hd_loop_osc_range)
    && $stable(audio_loop_pow2_divider); endproperty
  a_hold: assert property (p_hold) else $error("field moved");
  property p_pump2; s_wr(8'h2f) |=>
    hd_loop_pump_current == $past(reg_wdata[3:0]); endproperty
  a_pump2: assert property (p_pump2) else $error("hd pump");
  property p_pump3; s_wr(8'h32) |=>
    hd1001_loop_pump_current == $past(reg_wdata[3:0]); endproperty
  a_pump3: assert property (p_pump3) else $error("hd1001 pump");
  property p_osc2; s_wr(8'h30) |=>
    hd_loop_osc_range == $past(reg_wdata); endproperty
  a_osc2: assert property (p_osc2) else $error("hd osc range");
  property p_gate2; !hd_xpt_run |-> !hd_loop_run; endproperty
  a_gate2: assert property (p_gate2) else $error("hd forced on");
  property p_gate3; !hd1001_xpt_run |-> !hd1001_loop_run; endproperty
  a_gate3: assert property (p_gate3) else $error("hd1001 on");
endmodule
bind clkreg_bank clkreg_bank_monitor i_clkreg_bank_monitor (
  .mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_hit(reg_hit),
  .reg_rdata(reg_rdata), .hd_xpt_run(hd_xpt_run),
  .hd1001_xpt_run(hd1001_xpt_run), .hd_loop_halve(hd_loop_halve),
  .hd_loop_run(hd_loop_run),
  .hd_loop_pump_current(hd_loop_pump_current),
  .hd_loop_osc_range(hd_loop_osc_range),
  .hd1001_loop_halve(hd1001_loop_halve),
  .hd1001_loop_run(hd1001_loop_run),
  .hd1001_loop_pump_current(hd1001_loop_pump_current),
  .hd1001_loop_osc_range(hd1001_loop_osc_range),
  .audio_loop_pow2_divider(audio_loop_pow2_divider),
  .audio_loop_run(audio_loop_run),
  .audio_ref_freq_select(audio_ref_freq_select),
  .audio_ref_source_select(audio_ref_source_select),
  .audio_loop_pump_current(audio_loop_pump_current));
`default_nettype wire

/* bench/clkreg_bank_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module clkreg_bank_tb_top;
  logic mclk = 0, reset = 1, reg_wr = 0, reg_rd = 0, hd_xpt_run = 0;
  logic hd1001_xpt_run = 0, reg_hit, hd_loop_halve, hd_loop_run;
  logic hd1001_loop_halve, hd1001_loop_run, audio_loop_run;
  logic audio_ref_freq_select, audio_ref_source_select;
  logic [3:0] hd_loop_pump_current, hd1001_loop_pump_current;
  logic [3:0] audio_loop_pow2_divider, audio_loop_pump_current;
  clkreg_pkg::clkreg_byte_t reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  clkreg_pkg::clkreg_byte_t hd_loop_osc_range, hd1001_loop_osc_range;
  clkreg_pkg::clkreg_byte_t msk [8] = '{8'h18, 8'h0f, 8'hff, 8'h18,
    8'h0f, 8'hff, 8'hfb, 8'h0f};
  clkreg_pkg::clkreg_byte_t e0 [8] = '{8'h00, 8'h02, 8'h0c, 8'h00, 8'h03,
    8'h05, 8'h20, 8'h08};
  clkreg_pkg::clkreg_byte_t e [8];
  int num_errors = 0, check_count = 0;
  clkreg_bank i_clkreg_bank (
    .mclk(mclk), .reset(reset), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_hit(reg_hit),
    .reg_rdata(reg_rdata), .hd_xpt_run(hd_xpt_run),
    .hd1001_xpt_run(hd1001_xpt_run), .hd_loop_halve(hd_loop_halve),
    .hd_loop_run(hd_loop_run),
    .hd_loop_pump_current(hd_loop_pump_current),
    .hd_loop_osc_range(hd_loop_osc_range),
    .hd1001_loop_halve(hd1001_loop_halve),
    .hd1001_loop_run(hd1001_loop_run),
    .hd1001_loop_pump_current(hd1001_loop_pump_current),
    .hd1001_loop_osc_range(hd1001_loop_osc_range),
    .audio_loop_pow2_divider(audio_loop_pow2_divider),
    .audio_loop_run(audio_loop_run),
    .audio_ref_freq_select(audio_ref_freq_select),
    .audio_ref_source_select(audio_ref_source_select),
    .audio_loop_pump_current(audio_loop_pump_current));
  initial forever #4 mclk = ~mclk;
  task automatic chk(string n, logic [38:0] x, logic [38:0] s);
    check_count++;
    if (s !== x) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  function automatic logic [38:0] outs();
    return {e[0][4], hd_xpt_run & ~e[0][3], e[1][3:0], e[2], e[3][4],
      hd1001_xpt_run & ~e[3][3], e[4][3:0], e[5], e[6][7:4], ~e[6][3],
      e[6][1:0], e[7][3:0]};
  endfunction
  function automatic logic [38:0] seen();
    return {hd_loop_halve, hd_loop_run, hd_loop_pump_current,
      hd_loop_osc_range, hd1001_loop_halve, hd1001_loop_run,
      hd1001_loop_pump_current, hd1001_loop_osc_range,
      audio_loop_pow2_divider, audio_loop_run, audio_ref_freq_select,
      audio_ref_source_select, audio_loop_pump_current};
  endfunction
  task automatic after_reset();
    e = e0;
    chk("rdata after reset", 39'(0), 39'(reg_rdata));
    chk("outs after reset", outs(), seen());
  endtask
  task automatic acc(bit w, logic [7:0] a, logic [7:0] d);
    bit m;
    m = a inside {[8'h2e:8'h35]};
    @(negedge mclk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} = {w, !w, a, d};
    {hd_xpt_run, hd1001_xpt_run} = 2'($urandom);
    @(negedge mclk);
    {reg_wr, reg_rd} = 2'b00;
    chk("hit", 39'(m), 39'(reg_hit));
    if (m && w) e[a - 8'h2e] = d & msk[a - 8'h2e];
    if (!w) chk("rdata", m ? 39'(e[a - 8'h2e]) : 39'(0), 39'(reg_rdata));
    chk("outs", outs(), seen());
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8c66));
    repeat (12) @(negedge mclk);
    reset = 0;
    after_reset();
    for (int i = 0; i < 8; i++) acc(0, 8'h2e + 8'(i), 8'h00);
    for (int i = 0; i < 20; i++) acc(i[0], 8'h2c + 8'(i / 2), 8'hff);
    repeat (300) acc(1'($urandom), 8'h2c + 8'($urandom % 11), 8'($urandom));
    // Mid-run reset must bring every default back
    @(negedge mclk);
    reset = 1;
    repeat (3) @(negedge mclk);
    reset = 0;
    after_reset();
    for (int i = 0; i < 8; i++) acc(0, 8'h2e + 8'(i), 8'h00);
    stop_test();
  end
  initial begin
    #20000;
    num_errors++;
    stop_test();
  end
endmodule
`default_nettype wire

/* src/clkreg_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "clkreg_params.svh"

// Contract
// - HD and HD/1.001 halve bits: clear passes, set halves; default clear.
// - HD loop off bit clear follows crosspoint setting; set forces off.
// - HD/1.001 main bit 3 same: clear follows crosspoint, set forces off.
// - Audio output divided by two to power of bits 7:4; default 0010.
// - Audio bit 1 selects 100 MHz when clear, 125 MHz when set.
// - Audio bit 0 selects internal 27 MHz reference or external clock.
// - Pump current fields bits 3:0, defaults 0010, 0011, 1000.
// - Oscillator range full bytes, defaults 0x0c and 0x05.
module clkreg_bank (
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  reset,
  // Register port from serial management logic
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire clkreg_pkg::clkreg_addr_t reg_addr,
  input  wire clkreg_pkg::clkreg_byte_t reg_wdata,
  output logic                       reg_hit,
  output clkreg_pkg::clkreg_byte_t   reg_rdata,
  // Crosspoint requests for the video loops
  input  wire logic                  hd_xpt_run,
  input  wire logic                  hd1001_xpt_run,
  // Loop controls
  output logic                       hd_loop_halve,
  output logic                       hd_loop_run,
  output logic [3:0]                 hd_loop_pump_current,
  output clkreg_pkg::clkreg_byte_t   hd_loop_osc_range,
  output logic                       hd1001_loop_halve,
  output logic                       hd1001_loop_run,
  output logic [3:0]                 hd1001_loop_pump_current,
  output clkreg_pkg::clkreg_byte_t   hd1001_loop_osc_range,
  output logic [3:0]                 audio_loop_pow2_divider,
  output logic                       audio_loop_run,
  output logic                       audio_ref_freq_select,
  output logic                       audio_ref_source_select,
  output logic [3:0]                 audio_loop_pump_current
);

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  localparam int NREG = 8;

  // Tables are constants so the async reset loads no logic
  localparam clkreg_pkg::clkreg_addr_t REG_OFS [NREG] = '{
    `CLKREG_OFS_HD_MAIN,
    `CLKREG_OFS_HD_PUMP,
    `CLKREG_OFS_HD_OSC,
    `CLKREG_OFS_HD1001_MAIN,
    `CLKREG_OFS_HD1001_PUMP,
    `CLKREG_OFS_HD1001_OSC,
    `CLKREG_OFS_AUD_MAIN,
    `CLKREG_OFS_AUD_PUMP
  };

  localparam clkreg_pkg::clkreg_byte_t REG_RST [NREG] = '{
    `CLKREG_RST_HD_MAIN,
    `CLKREG_RST_HD_PUMP,
    `CLKREG_RST_HD_OSC,
    `CLKREG_RST_HD1001_MAIN,
    `CLKREG_RST_HD1001_PUMP,
    `CLKREG_RST_HD1001_OSC,
    `CLKREG_RST_AUD_MAIN,
    `CLKREG_RST_AUD_PUMP
  };

  // Masks keep reserved bits at zero
  localparam clkreg_pkg::clkreg_byte_t REG_MSK [NREG] = '{
    `CLKREG_MSK_LOOP_MAIN,
    `CLKREG_MSK_PUMP,
    `CLKREG_MSK_FULL,
    `CLKREG_MSK_LOOP_MAIN,
    `CLKREG_MSK_PUMP,
    `CLKREG_MSK_FULL,
    `CLKREG_MSK_AUD_MAIN,
    `CLKREG_MSK_PUMP
  };

  clkreg_pkg::clkreg_byte_t regs_ff   [NREG];
  clkreg_pkg::clkreg_byte_t nxt_regs  [NREG];
  logic [NREG-1:0]          sel;
  logic [NREG-1:0]          wr_en;
  clkreg_pkg::clkreg_byte_t rd_mux;
  clkreg_pkg::clkreg_byte_t nxt_rdata;

  // Named views of the stored bytes
  clkreg_pkg::clkreg_byte_t hd_main;
  clkreg_pkg::clkreg_byte_t hd_pump;
  clkreg_pkg::clkreg_byte_t hd_osc;
  clkreg_pkg::clkreg_byte_t hd1001_main;
  clkreg_pkg::clkreg_byte_t hd1001_pump;
  clkreg_pkg::clkreg_byte_t hd1001_osc;
  clkreg_pkg::clkreg_byte_t aud_main;
  clkreg_pkg::clkreg_byte_t aud_pump;

  // Field slices
  logic                     hd_halve_bit;
  logic                     hd_off_bit;
  logic [3:0]               hd_pump_field;

  logic                     hd1001_halve_bit;
  logic                     hd1001_off_bit;
  logic [3:0]               hd1001_pump_field;

  logic [3:0]               aud_pow2_field;
  logic                     aud_off_bit;
  logic                     aud_freq_bit;
  logic                     aud_src_bit;
  logic [3:0]               aud_pump_field;

  // ----------------------------------------
  // Per-register decode and write
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NREG; gi++) begin : g_reg
      // One comparator per register
      assign sel[gi]      = (reg_addr == REG_OFS[gi]);
      assign wr_en[gi]    = reg_wr & sel[gi];
      // Write data masked before storage, reserved bits stay zero
      assign nxt_regs[gi] = wr_en[gi] ? (reg_wdata & REG_MSK[gi])
                                      : regs_ff[gi];
      always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
          regs_ff[gi] <= REG_RST[gi];
        end else begin
          regs_ff[gi] <= nxt_regs[gi];
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  // Offsets are distinct, so the priority order never matters
  assign rd_mux = sel[0] ? regs_ff[0] :
                  sel[1] ? regs_ff[1] :
                  sel[2] ? regs_ff[2] :
                  sel[3] ? regs_ff[3] :
                  sel[4] ? regs_ff[4] :
                  sel[5] ? regs_ff[5] :
                  sel[6] ? regs_ff[6] :
                  sel[7] ? regs_ff[7] :
                  8'h00;

  // Data held between reads; read beside a write returns old byte
  assign nxt_rdata = reg_rd ? rd_mux : reg_rdata;
  // Hit flag is combinational so the serial side can answer at once
  assign reg_hit   = |sel;

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Register views and field slices
  // ----------------------------------------
  assign hd_main     = regs_ff[0];
  assign hd_pump     = regs_ff[1];
  assign hd_osc      = regs_ff[2];

  assign hd1001_main = regs_ff[3];
  assign hd1001_pump = regs_ff[4];
  assign hd1001_osc  = regs_ff[5];

  assign aud_main    = regs_ff[6];
  assign aud_pump    = regs_ff[7];

  assign hd_halve_bit      = hd_main[`CLKREG_BIT_HALVE];
  assign hd_off_bit        = hd_main[`CLKREG_BIT_OFF];
  assign hd_pump_field     = hd_pump[3:0];

  assign hd1001_halve_bit  = hd1001_main[`CLKREG_BIT_HALVE];
  assign hd1001_off_bit    = hd1001_main[`CLKREG_BIT_OFF];
  assign hd1001_pump_field = hd1001_pump[3:0];

  assign aud_pow2_field    = aud_main[7:4];
  assign aud_off_bit       = aud_main[`CLKREG_BIT_OFF];
  assign aud_freq_bit      = aud_main[`CLKREG_BIT_FREQ];
  assign aud_src_bit       = aud_main[`CLKREG_BIT_SRC];
  assign aud_pump_field    = aud_pump[3:0];

  // ----------------------------------------
  // HD loop controls
  // ----------------------------------------
  assign hd_loop_halve = hd_halve_bit;
  // Off bit overrides crosspoint, never forces on
  assign hd_loop_run = hd_xpt_run & ~hd_off_bit;
  // Pump and range bytes go to the analog side untouched
  assign hd_loop_pump_current = hd_pump_field;
  assign hd_loop_osc_range = hd_osc;

  // ----------------------------------------
  // HD/1.001 loop controls
  // ----------------------------------------
  assign hd1001_loop_halve = hd1001_halve_bit;
  // Same off override as the HD loop, from the same bit 3 position
  assign hd1001_loop_run = hd1001_xpt_run & ~hd1001_off_bit;
  assign hd1001_loop_pump_current = hd1001_pump_field;
  assign hd1001_loop_osc_range = hd1001_osc;

  // ----------------------------------------
  // Audio loop controls
  // ----------------------------------------
  // Divider exponent passed on raw, the loop does the shifting
  assign audio_loop_pow2_divider = aud_pow2_field;
  assign audio_loop_run = ~aud_off_bit;
  assign audio_ref_freq_select = aud_freq_bit;
  assign audio_ref_source_select = aud_src_bit;
  assign audio_loop_pump_current = aud_pump_field;

endmodule
`default_nettype wire

/* src/clkreg_params.svh */
`ifndef CLKREG_PARAMS_SVH
`define CLKREG_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define CLKREG_OFS_HD_MAIN      8'h2e
`define CLKREG_OFS_HD_PUMP      8'h2f
`define CLKREG_OFS_HD_OSC       8'h30
`define CLKREG_OFS_HD1001_MAIN  8'h31
`define CLKREG_OFS_HD1001_PUMP  8'h32
`define CLKREG_OFS_HD1001_OSC   8'h33
`define CLKREG_OFS_AUD_MAIN     8'h34
`define CLKREG_OFS_AUD_PUMP     8'h35

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CLKREG_BIT_HALVE        4
`define CLKREG_BIT_OFF          3
`define CLKREG_BIT_FREQ         1
`define CLKREG_BIT_SRC          0

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define CLKREG_RST_HD_MAIN      8'h00
`define CLKREG_RST_HD_PUMP      8'h02
`define CLKREG_RST_HD_OSC       8'h0c
`define CLKREG_RST_HD1001_MAIN  8'h00
`define CLKREG_RST_HD1001_PUMP  8'h03
`define CLKREG_RST_HD1001_OSC   8'h05
`define CLKREG_RST_AUD_MAIN     8'h20
`define CLKREG_RST_AUD_PUMP     8'h08
`define CLKREG_MSK_LOOP_MAIN    8'h18
`define CLKREG_MSK_PUMP         8'h0f
`define CLKREG_MSK_FULL         8'hff
`define CLKREG_MSK_AUD_MAIN     8'hfb

`endif

/* src/clkreg_pkg.sv */
package clkreg_pkg;
  typedef logic [7:0] clkreg_byte_t;
  typedef logic [7:0] clkreg_addr_t;
endpackage
